// ---- src/ebus_pkg.sv ----
// Constants and types shared by the external bus master files
package ebus_pkg;

  // ==========================================================
  // Clock and bus timing
  // ==========================================================
  localparam int CLK_NS = 4;     // System clock period
  localparam int HALF_NS = 8;    // Bus half period
  // Half period in clock cycles, rounded up
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);

  // ==========================================================
  // Address space codes
  // ==========================================================
  localparam logic [2:0] SPACE_USER_DATA = 3'h1;
  localparam logic [2:0] SPACE_USER_PROG = 3'h2;
  localparam logic [2:0] SPACE_SUP_DATA = 3'h5;
  localparam logic [2:0] SPACE_SUP_PROG = 3'h6;
  localparam logic [2:0] SPACE_CPU = 3'h7;

  // ==========================================================
  // Size line codes, size_hi then size_lo
  // ==========================================================
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;
  localparam logic [1:0] SIZE_LONG = 2'h0;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam int SYNC_W = 21;                      // Synchronised pins
  localparam logic [20:0] SYNC_RST = 21'h1fffff;   // Pins idle high
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [3:0] TICK_RST = 4'h0;

  // ==========================================================
  // Bus cycle sequencer states
  // ==========================================================
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_STRB = 6'h04,
    ST_WDAT = 6'h08,
    ST_WAIT = 6'h10,
    ST_END = 6'h20
  } bus_state_e;

endpackage

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for the bus input pins
`timescale 1ns/100ps
module pin_sync
  import ebus_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Pins in, synchronised copy out
  input wire logic [SYNC_W-1:0] pins,
  output logic [SYNC_W-1:0] pins_sync
);

  logic [SYNC_W-1:0] meta_ff; // First stage, read only by second
  logic [SYNC_W-1:0] sync_ff; // Second stage

  // ==========================================================
  // One two-flop chain per pin
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_bit
      // Chain for one pin
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          meta_ff[gi] <= SYNC_RST[gi];
          sync_ff[gi] <= SYNC_RST[gi];
        end else begin
          meta_ff[gi] <= pins[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  assign pins_sync = sync_ff;

endmodule

// ---- src/half_ticker.sv ----
// Bus half-period tick generator
`timescale 1ns/100ps
module half_ticker
  import ebus_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Restart aligns the next half period
  input wire logic restart,
  output logic tick
);

  logic [3:0] cnt_ff; // Cycles into the half period

  // ==========================================================
  // Free-running count, restarted at a new transfer
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= TICK_RST;
    end else if (restart || cnt_ff == HALF_LAST) begin
      cnt_ff <= TICK_RST;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // Last cycle of each half period
  assign tick = (cnt_ff == HALF_LAST);

endmodule

// ---- src/ebus_master.sv ----
// Asynchronous external bus master with dynamic bus sizing
// Functional notes
// - Space code marks user, supervisor, control space
// - Address of leading byte held during strobe
// - Address strobe falls half period after start
// - Read data captured at the cycle's last sample
// - Writes drive all sixteen data lines
// - Write data driven half period after strobe
// - Read data strobe falls with address strobe
// - Write data strobe one period after strobe
// - Acknowledge pair: wait, 8-bit, 16-bit, reserved
// - Bus fault ends the cycle as error
// - Fault with halt raises bus exception
// - Autovector ends only interrupt acknowledge cycles
// - Long word: two 16-bit or four 8-bit cycles
// - Assume 16-bit port, continue after 8-bit ack
// - Operand bytes numbered from most significant
// - Size lines give bytes still to move
// - Word base plus byte offset steer lanes
// - Odd word or long requests are refused
// - Long word: high word first, then low
// - Size codes: 01,10,11,00 for 1,2,3,4
`timescale 1ns/100ps
module ebus_master
  import ebus_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Transfer request
  input wire logic req,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [2:0] req_space,
  input wire logic [23:0] req_addr,
  input wire logic [31:0] req_wdata,
  // Transfer result
  output logic busy,
  output logic done,
  output logic reject,
  output logic fault,
  output logic fault_exc,
  output logic autovec,
  output logic [31:0] rdata,
  // Bus outputs
  output logic [23:0] addr,
  output logic [2:0] space_code,
  output logic size_hi,
  output logic size_lo,
  output logic read_write,
  output logic addr_strobe_n,
  output logic data_strobe_n,
  output logic [15:0] data_out,
  output logic data_oe_n,
  // Bus inputs
  input wire logic [15:0] data_in,
  input wire logic ack_hi_n,
  input wire logic ack_lo_n,
  input wire logic bus_fault_n,
  input wire logic halt_n,
  input wire logic auto_vector_n
);

  // ==========================================================
  // Declarations
  // ==========================================================
  bus_state_e state_ff;          // Cycle sequencer
  logic phase_ff;                // Sample slot inside wait
  logic [23:0] base_ff;          // Operand start address
  logic [1:0] idx_ff;            // Operand bytes already moved
  logic [2:0] rem_ff;            // Operand bytes left
  logic [2:0] tot_ff;            // Operand length in bytes
  logic write_ff;                // Transfer direction
  logic iack_ff;                 // Interrupt acknowledge transfer
  logic more_ff;                 // Another cycle follows
  logic [31:0] opbuf_ff;         // Write operand, byte 0 on top
  logic [31:0] rbuf_ff;          // Read operand, byte 0 on top
  logic flt_ff;                  // Transfer ended by bus fault
  logic exc_ff;                  // Fault came with halt
  logic av_ff;                   // Transfer ended by autovector
  logic [23:0] addr_ff;
  logic [2:0] space_ff;
  logic [1:0] size_ff;
  logic rw_ff;
  logic as_n_ff;
  logic ds_n_ff;
  logic [15:0] wdata_ff;
  logic oe_n_ff;
  logic busy_ff;
  logic done_ff;
  logic reject_ff;
  logic fault_ff;
  logic fault_exc_ff;
  logic autovec_ff;
  logic [31:0] rdata_ff;
  logic [SYNC_W-1:0] sync_q;     // Synchronised pins
  logic tick;                    // End of a half period
  logic ack_hi_s, ack_lo_s, flt_s, halt_s, av_s;
  logic [15:0] din_s;
  logic accept, bad_req, go, sample, t8, t16, flt, av, hit;
  logic finish;
  logic [2:0] step;
  logic [2:0] req_bytes;
  logic [1:0] nidx;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Operand byte k, byte 0 most significant
  function automatic logic [7:0] op_byte(input logic [31:0] v,
                                         input logic [1:0] k);
    op_byte = v[{~k, 3'h0} +: 8];
  endfunction

  // ==========================================================
  // Pin synchroniser and half-period timer
  // ==========================================================
  pin_sync u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .pins({ack_hi_n, ack_lo_n, bus_fault_n, halt_n, auto_vector_n,
           data_in}),
    .pins_sync(sync_q)
  );

  half_ticker u_tick (
    .clock(clock),
    .arst_n(arst_n),
    .restart(go),
    .tick(tick)
  );

  assign ack_hi_s = sync_q[20];
  assign ack_lo_s = sync_q[19];
  assign flt_s = sync_q[18];
  assign halt_s = sync_q[17];
  assign av_s = sync_q[16];
  assign din_s = sync_q[15:0];

  // ==========================================================
  // Request decode
  // ==========================================================
  // Byte count of the requested operand, four for both the long and the three-byte codes
  always_comb begin
    unique case (req_size)
      SIZE_BYTE: req_bytes = 3'h1;
      SIZE_WORD: req_bytes = 3'h2;
      default: req_bytes = 3'h4;
    endcase
  end

  assign accept = req && (state_ff == ST_IDLE);
  // Odd word or long, or a reserved space, is refused
  assign bad_req = (req_addr[0] && req_size != SIZE_BYTE)
                || !(req_space == SPACE_USER_DATA
                  || req_space == SPACE_USER_PROG
                  || req_space == SPACE_SUP_DATA
                  || req_space == SPACE_SUP_PROG
                  || req_space == SPACE_CPU);
  assign go = accept && !bad_req;

  // ==========================================================
  // Termination decode
  // ==========================================================
  // Sample once per full period while waiting
  assign sample = (state_ff == ST_WAIT) && tick && phase_ff;
  assign t8 = ack_hi_s && !ack_lo_s;
  assign t16 = !ack_hi_s && ack_lo_s;
  assign flt = !flt_s;
  assign av = !av_s && iack_ff;
  assign hit = sample && (t8 || t16 || flt || av);
  // Two bytes only on a 16-bit ack at an even address
  assign step = (t16 && !addr_ff[0] && rem_ff >= 3'h2) ? 3'h2 : 3'h1;
  assign nidx = idx_ff + 2'h1;
  assign finish = (state_ff == ST_END) && tick && !more_ff;

  // ==========================================================
  // Cycle sequencer
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (go) begin
            state_ff <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (tick) begin
            state_ff <= ST_STRB;
          end
        end
        ST_STRB: begin
          if (tick) begin
            state_ff <= write_ff ? ST_WDAT : ST_WAIT;
          end
        end
        ST_WDAT: begin
          if (tick) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (hit) begin
            state_ff <= ST_END;
          end
        end
        ST_END: begin
          if (tick) begin
            state_ff <= more_ff ? ST_ADDR : ST_IDLE;
          end
        end
      endcase
    end
  end

  // Wait phase, first slot samples at once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= 1'b1;
    end else if (state_ff != ST_WAIT) begin
      phase_ff <= 1'b1;
    end else if (tick) begin
      phase_ff <= ~phase_ff;
    end
  end

  // ==========================================================
  // Operand bookkeeping
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      base_ff <= ADDR_RST;
      idx_ff <= 2'h0;
      rem_ff <= 3'h0;
      tot_ff <= 3'h0;
      write_ff <= 1'b0;
      iack_ff <= 1'b0;
      more_ff <= 1'b0;
      opbuf_ff <= WORD_RST;
      flt_ff <= 1'b0;
      exc_ff <= 1'b0;
      av_ff <= 1'b0;
    end else if (go) begin
      // Left-justify so byte 0 is most significant
      base_ff <= req_addr;
      idx_ff <= 2'h0;
      rem_ff <= req_bytes;
      tot_ff <= req_bytes;
      write_ff <= req_write;
      iack_ff <= (req_space == SPACE_CPU);
      more_ff <= 1'b0;
      flt_ff <= 1'b0;
      exc_ff <= 1'b0;
      av_ff <= 1'b0;
      unique case (req_size)
        SIZE_BYTE: opbuf_ff <= {req_wdata[7:0], 24'h000000};
        SIZE_WORD: opbuf_ff <= {req_wdata[15:0], 16'h0000};
        default: opbuf_ff <= req_wdata;
      endcase
    end else if (hit) begin
      // Fault wins, then autovector, then data ack
      flt_ff <= flt;
      exc_ff <= flt && !halt_s;
      av_ff <= !flt && av;
      more_ff <= !flt && !av && (rem_ff > step);
      if (!flt && !av) begin
        idx_ff <= idx_ff + step[1:0];
        rem_ff <= rem_ff - step;
      end
    end
  end

  // ==========================================================
  // Address, space, size and direction outputs
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff <= ADDR_RST;
      space_ff <= 3'h0;
      size_ff <= SIZE_LONG;
      rw_ff <= 1'b1;
    end else if (go) begin
      addr_ff <= req_addr;
      space_ff <= req_space;
      size_ff <= req_bytes[1:0];
      rw_ff <= !req_write;
    end else if ((state_ff == ST_END) && tick && more_ff) begin
      // Next part: word base plus offset of next byte
      addr_ff <= base_ff + {22'h000000, idx_ff};
      size_ff <= rem_ff[1:0];
    end
  end

  // ==========================================================
  // Strobes
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      as_n_ff <= 1'b1;
      ds_n_ff <= 1'b1;
    end else if ((state_ff == ST_ADDR) && tick) begin
      as_n_ff <= 1'b0;
      ds_n_ff <= write_ff;
    end else if ((state_ff == ST_WDAT) && tick) begin
      ds_n_ff <= 1'b0;
    end else if (hit) begin
      as_n_ff <= 1'b1;
      ds_n_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Write data lanes
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wdata_ff <= DATA_RST;
      oe_n_ff <= 1'b1;
    end else if ((state_ff == ST_STRB) && tick && write_ff) begin
      // Upper lane always carries the current byte
      oe_n_ff <= 1'b0;
      wdata_ff[15:8] <= op_byte(opbuf_ff, idx_ff);
      if (addr_ff[0]) begin
        wdata_ff[7:0] <= op_byte(opbuf_ff, idx_ff);
      end else begin
        wdata_ff[7:0] <= op_byte(opbuf_ff, nidx);
      end
    end else if ((state_ff == ST_END) && tick) begin
      oe_n_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Read data capture
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rbuf_ff <= WORD_RST;
    end else if (go) begin
      rbuf_ff <= WORD_RST;
    end else if (hit && !write_ff && !flt && !av) begin
      if (t8) begin
        // Byte port lives on the upper lane
        rbuf_ff[{~idx_ff, 3'h0} +: 8] <= din_s[15:8];
      end else if (addr_ff[0]) begin
        rbuf_ff[{~idx_ff, 3'h0} +: 8] <= din_s[7:0];
      end else begin
        rbuf_ff[{~idx_ff, 3'h0} +: 8] <= din_s[15:8];
        if (step == 3'h2) begin
          rbuf_ff[{~nidx, 3'h0} +: 8] <= din_s[7:0];
        end
      end
    end
  end

  // ==========================================================
  // Result reporting
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      reject_ff <= 1'b0;
      fault_ff <= 1'b0;
      fault_exc_ff <= 1'b0;
      autovec_ff <= 1'b0;
      rdata_ff <= WORD_RST;
    end else begin
      done_ff <= finish;
      reject_ff <= accept && bad_req;
      fault_ff <= finish && flt_ff;
      fault_exc_ff <= finish && exc_ff;
      autovec_ff <= finish && av_ff;
      if (go) begin
        busy_ff <= 1'b1;
      end else if (finish) begin
        busy_ff <= 1'b0;
      end
      // Right-justify the read operand
      if (finish && !write_ff) begin
        unique case (tot_ff)
          3'h1: rdata_ff <= {24'h000000, rbuf_ff[31:24]};
          3'h2: rdata_ff <= {16'h0000, rbuf_ff[31:16]};
          default: rdata_ff <= rbuf_ff;
        endcase
      end
    end
  end

  // Ports straight from flops
  assign busy = busy_ff;
  assign done = done_ff;
  assign reject = reject_ff;
  assign fault = fault_ff;
  assign fault_exc = fault_exc_ff;
  assign autovec = autovec_ff;
  assign rdata = rdata_ff;
  assign addr = addr_ff;
  assign space_code = space_ff;
  assign size_hi = size_ff[1];
  assign size_lo = size_ff[0];
  assign read_write = rw_ff;
  assign addr_strobe_n = as_n_ff;
  assign data_strobe_n = ds_n_ff;
  assign data_out = wdata_ff;
  assign data_oe_n = oe_n_ff;

  // ==========================================================
  // Checks
  // ==========================================================
  as_delay_a: assert property (@(posedge clock) disable iff (!arst_n)
    go |=> as_n_ff [*2] ##1 !as_n_ff)
    else $error("address strobe not half period after start");

  addr_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!as_n_ff && $past(!as_n_ff)) |-> $stable(addr_ff)
      && $stable(space_ff))
    else $error("address moved while strobe asserted");

  rd_strobe_a: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(as_n_ff) && rw_ff) |-> $fell(ds_n_ff))
    else $error("read data strobe not with address strobe");

  wr_strobe_a: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(as_n_ff) && !rw_ff) |-> ds_n_ff [*4] ##1 !ds_n_ff)
    else $error("write data strobe not one period late");

  wr_data_a: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(as_n_ff) && !rw_ff) |-> oe_n_ff [*2] ##1 !oe_n_ff)
    else $error("write data not half period after strobe");

  full_drive_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!ds_n_ff && !rw_ff) |-> !oe_n_ff)
    else $error("write strobe without data drive");

  size_code_a: assert property (@(posedge clock) disable iff (!arst_n)
    !as_n_ff |-> (size_ff == rem_ff[1:0]) && (rem_ff != 3'h0))
    else $error("size lines differ from bytes left");

  wait_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_ff == ST_WAIT && $past(state_ff) == ST_WAIT)
      |-> $stable(wdata_ff) && !as_n_ff && $stable(ds_n_ff))
    else $error("outputs moved during wait states");

  misalign_a: assert property (@(posedge clock) disable iff (!arst_n)
    (accept && req_addr[0] && req_size != SIZE_BYTE)
      |=> reject_ff && !busy_ff)
    else $error("odd word request not refused");

  fault_end_a: assert property (@(posedge clock) disable iff (!arst_n)
    (hit && flt) |-> ##[1:4] (done_ff && fault_ff))
    else $error("bus fault did not end transfer");

endmodule

// ---- verif/bus_slave_model.sv ----
// Behavioural memory on the far side of the external bus
`timescale 1ns/100ps
module bus_slave_model (
  // Clock
  input wire logic clock,
  // Port behaviour chosen by the bench
  input wire logic wide,
  input wire logic mute,
  input wire logic [1:0] waits,
  // Bus from the master
  input wire logic [23:0] addr,
  input wire logic size_hi,
  input wire logic size_lo,
  input wire logic read_write,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic [15:0] data_out,
  // Answers to the master
  output logic [15:0] data_in,
  output logic ack_hi_n,
  output logic ack_lo_n
);
  logic [7:0] mem [16]; // Byte store, low address bits only
  logic [3:0] a; // Byte index
  logic tgl; // Idle bus pattern
  int cnt; // Wait states so far
  assign a = addr[3:0];
  // Both lanes on a wide port, upper lane only on a narrow one
  always_comb begin
    if (ack_hi_n && ack_lo_n)
      data_in = {16{tgl}} ^ 16'h5a5a;
    else if (wide)
      data_in = {mem[{a[3:1], 1'b0}], mem[{a[3:1], 1'b1}]};
    else
      data_in = {mem[a], ~mem[a]};
  end
  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
    ack_hi_n = 1'b1;
    ack_lo_n = 1'b1;
    tgl = 1'b0;
    cnt = 0;
  end
  // Acknowledge after the chosen waits, hold until strobe release
  always @(posedge clock) begin
    tgl <= ~tgl;
    if (addr_strobe_n) begin
      cnt <= 0;
      ack_hi_n <= 1'b1;
      ack_lo_n <= 1'b1;
    end else if (!data_strobe_n && !mute && ack_hi_n && ack_lo_n) begin
      cnt <= cnt + 1;
      if (cnt >= waits) begin
        ack_hi_n <= !wide;
        ack_lo_n <= wide;
        if (!read_write) begin
          if (wide && !a[0] && {size_hi, size_lo} != 2'h1) begin
            mem[a] <= data_out[15:8];
            mem[{a[3:1], 1'b1}] <= data_out[7:0];
          end else
            mem[a] <= (wide && a[0]) ? data_out[7:0] : data_out[15:8];
        end
      end
    end
  end
endmodule

// ---- verif/ebus_master_tb_top.sv ----
// Self-checking bench for the external bus master
`timescale 1ns/100ps
module ebus_master_tb_top;
  import ebus_pkg::*;
  // Request side and control pins
  logic clock = 0, arst_n = 0, req = 0, req_write = 0, wide = 1, mute = 0;
  logic [1:0] req_size = 2'h1, waits = 2'h0, first_size, sz;
  logic [2:0] req_space = 3'h1;
  logic [23:0] req_addr = 24'h0, ad;
  logic [31:0] req_wdata = 32'h0, rdata, wd;
  logic bus_fault_n = 1, halt_n = 1, auto_vector_n = 1;
  // Design outputs and bus
  logic busy, done, reject, fault, fault_exc, autovec, size_hi, size_lo;
  logic [23:0] addr;
  logic [2:0] space_code;
  logic read_write, addr_strobe_n, data_strobe_n, data_oe_n;
  logic [15:0] data_out, data_in;
  logic ack_hi_n, ack_lo_n;
  logic [4:0] flags; // done, reject, fault, fault_exc, autovec
  logic went; // Busy seen the cycle after the request
  logic [7:0] mirror [16]; // Expected memory
  int mismatches = 0, tests_run = 0, cycles = 0, strobes = 0, n;
  ebus_master DUT (.clock, .arst_n, .req, .req_write, .req_size,
    .req_space, .req_addr, .req_wdata, .busy, .done, .reject, .fault,
    .fault_exc, .autovec, .rdata, .addr, .space_code, .size_hi, .size_lo,
    .read_write, .addr_strobe_n, .data_strobe_n, .data_out, .data_oe_n,
    .data_in, .ack_hi_n, .ack_lo_n, .bus_fault_n, .halt_n, .auto_vector_n);
  bus_slave_model slave (.clock, .wide, .mute, .waits, .addr, .size_hi,
    .size_lo, .read_write, .addr_strobe_n, .data_strobe_n, .data_out,
    .data_in, .ack_hi_n, .ack_lo_n);
  always #2 clock = ~clock;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  // Bus cycles per transfer and size lines of the first one
  always @(negedge addr_strobe_n) begin
    if (strobes == 0) begin
      first_size = {size_hi, size_lo};
      check(addr, req_addr);
    end
    check({space_code, read_write}, {req_space, !req_write});
    strobes++;
  end
  // Write data must be driven while the data strobe is low
  always @(negedge clock) begin
    if (arst_n && !read_write && !data_strobe_n)
      check(data_oe_n, 1'b0);
  end
  // One transfer, flags gathered at its end
  task automatic xfer(input logic w, input logic [1:0] s, input logic [2:0] p);
    @(negedge clock);
    {req, req_write, req_size, req_space, req_addr, req_wdata} =
      {1'b1, w, s, p, ad, wd};
    strobes = 0;
    @(negedge clock);
    req = 0;
    went = busy;
    flags = 5'h00;
    for (int i = 0; i < 400 && flags === 5'h00; i++) begin
      flags = {done, reject, fault, fault_exc, autovec};
      if (flags === 5'h00)
        @(negedge clock);
    end
  endtask
  function automatic logic [31:0] exp_read(input int k);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < k; i++)
      v = {v[23:0], mirror[4'(ad[3:0] + i)]};
    return v;
  endfunction
  // Main sequence
  initial begin
    logic [2:0] legal [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    logic [1:0] sizes [3] = '{2'h1, 2'h2, 2'h0};
    logic [5:0] bad [6] = '{6'h04, 6'h1c, 6'h24, 6'h0d, 6'h11, 6'h17};
    void'($urandom(32'hc22e));
    foreach (mirror[k]) mirror[k] = 8'h00;
    repeat (20) @(negedge clock);
    arst_n = 1;
    repeat (3) @(negedge clock);
    for (int t = 0; t < 48; t++) begin
      sz = sizes[$urandom_range(2)];
      ad = 24'($urandom);
      wd = $urandom;
      wide = 1'($urandom);
      waits = 2'($urandom);
      if (t == 0) begin
        {sz, ad, wide, waits} = {2'h0, 24'h00000e, 1'b0, 2'h3};
      end
      n = (sz == 2'h1) ? 1 : (sz == 2'h2) ? 2 : 4;
      if (n > 1)
        ad[0] = 1'b0;
      xfer(1'b1, sz, legal[$urandom_range(4)]);
      check(flags, 5'h10);
      check({went, busy}, 2'h2);
      check(strobes, wide ? (n == 4 ? 2 : 1) : n);
      check(first_size, sz);
      for (int j = 0; j < n; j++)
        mirror[4'(ad[3:0] + j)] = 8'(wd >> (8 * (n - 1 - j)));
      xfer(1'b0, sz, legal[$urandom_range(4)]);
      check(flags, 5'h10);
      check(rdata & ((32'h1 << (8 * n)) - 1), exp_read(n));
      check(strobes, wide ? (n == 4 ? 2 : 1) : n);
    end
    // Reserved spaces and odd word or long addresses
    foreach (bad[k]) begin
      ad = {23'h0, bad[k][0]};
      xfer(1'b0, bad[k][2:1], bad[k][5:3]);
      check(flags, 5'h08);
      check(went, 1'b0);
      check(strobes, 0);
    end
    // Bus fault with and without halt, remaining bytes dropped
    {mute, bus_fault_n, ad} = {1'b1, 1'b0, 24'h0};
    for (int h = 0; h < 2; h++) begin
      halt_n = h[0];
      xfer(1'b0, 2'h0, 3'h1);
      check(flags, h ? 5'h14 : 5'h16);
      check(strobes, 1);
    end
    {bus_fault_n, halt_n, auto_vector_n} = 3'h6;
    // Autovector ends control space cycles only
    xfer(1'b0, 2'h1, 3'h7);
    check(flags, 5'h11);
    mute = 0;
    xfer(1'b0, 2'h1, 3'h1);
    check(flags, 5'h10);
    tally_and_finish;
  end
endmodule
